// ### hbd_assertions.sv
// hbd_assertions: timing checks on the shared host bus wires.
// assumes host style and device straps carry the same code.
`timescale 1ns/1ps
module hbd_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic address_strobe,
  input wire logic [15:0] addr,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic [7:0] host_dout,
  input wire logic host_doe,
  input wire logic dev_doe,
  input wire logic [2:0] bus_style_straps
);
  // ----------------------------------------------------------------
  // strobe decode per style
  // ----------------------------------------------------------------
  logic sep;
  logic act;
  logic rd_sel;
  assign sep = bus_style_straps != hbd_pkg::STRAP_ENA &&
               bus_style_straps != hbd_pkg::STRAP_LDS;
  // enable strobe is active high, the other two active low
  assign act = sep ? (!rd_pin || !wr_pin) :
    (bus_style_straps == hbd_pkg::STRAP_ENA ? wr_pin : !wr_pin);
  assign rd_sel = sep ? !rd_pin : rd_pin;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_NO_FIGHT: assert property (!(host_doe && dev_doe))
    else $error("both ends drive data");
  AST_ONE_STROBE: assert property (sep |-> rd_pin || wr_pin)
    else $error("read and write strobes together");
  AST_ADDR_STABLE: assert property (!cs_n && $past(!cs_n) |->
    $stable(addr)) else $error("select moved in cycle");
  AST_DATA_STABLE: assert property (host_doe && $past(host_doe) |->
    $stable(host_dout)) else $error("write data moved");
  AST_CS_LEN: assert property ($fell(cs_n) |-> ##17 !cs_n ##1 cs_n)
    else $error("chip select length wrong");
  AST_IDLE_GAP: assert property ($rose(cs_n) |=> cs_n)
    else $error("no idle cycle between cycles");
  AST_STROBE_IN_CS: assert property ($rose(act) |->
    !cs_n && address_strobe) else $error("strobe outside select");
  AST_STROBE_LEN: assert property ($rose(act) |->
    act[*8] ##4 act ##1 !act) else $error("strobe length wrong");
  AST_READ_SEL: assert property ($rose(dev_doe) |->
    rd_sel && addr[0] && !cs_n) else $error("drive without read");
  AST_DEV_DOE_LEN: assert property ($rose(dev_doe) |-> dev_doe[*8])
    else $error("read drive too short");
endmodule

// ### hbd_bus_if.sv
// hbd_bus_if: the 8-bit parallel host bus between host and device.
// assumes at most one side enables its data drivers; idle bus floats high.
`timescale 1ns/1ps
interface hbd_bus_if;
  logic cs_n;
  logic address_strobe;
  logic [15:0] addr;
  logic rd_pin;
  logic wr_pin;
  logic [7:0] host_dout;
  logic host_doe;
  logic [7:0] dev_dout;
  logic dev_doe;
  logic [7:0] data;

  // resolved wire level; pull-up when nobody drives
  assign data = dev_doe ? dev_dout : (host_doe ? host_dout : hbd_pkg::BUS_FLOAT);

  modport host (
    output cs_n,
    output address_strobe,
    output addr,
    output rd_pin,
    output wr_pin,
    output host_dout,
    output host_doe,
    input data
  );

  modport dev (
    input cs_n,
    input address_strobe,
    input addr,
    input rd_pin,
    input wr_pin,
    input data,
    output dev_dout,
    output dev_doe
  );
endinterface

// ### hbd_dev.sv
// hbd_dev: device end; decodes host bus cycles into command/data writes
// and display reads. assumes cs is decoded from the upper address outside.
`timescale 1ns/1ps
module hbd_dev (
  input wire logic clock,
  input wire logic rst_n,
  hbd_bus_if.dev bus,
  input wire logic [2:0] bus_style_straps,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic wr_is_cmd,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_value,
  output logic rd_strobe,
  output logic overrun
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [2:0] st1;
    logic [2:0] st2;
    logic [2:0] style;
    logic [1:0] boot;
    logic rd_act;
    logic wr_act;
    logic pend;
    logic [hbd_pkg::BUF_WORD_W-1:0] pend_w;
    logic [hbd_pkg::BUF_DEPTH-1:0] v;
    logic [hbd_pkg::BUF_DEPTH-1:0][hbd_pkg::BUF_WORD_W-1:0] w;
    logic [7:0] dout;
    logic doe;
    logic rd_stb;
    logic ovr;
  } hbd_dev_st_t;

  hbd_dev_st_t q;
  hbd_dev_st_t n;

  always_comb begin
    logic sel;
    logic a0;
    logic rp;
    logic wp;
    logic rd_now;
    logic wr_now;
    logic pop;
    logic acc;
    sel = 1'b0;
    a0 = 1'b0;
    rp = 1'b0;
    wp = 1'b0;
    rd_now = 1'b0;
    wr_now = 1'b0;
    pop = 1'b0;
    acc = 1'b0;
    n = q;
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    n.s1 = {bus.cs_n, bus.address_strobe, bus.addr[0], bus.rd_pin,
            bus.wr_pin};
    n.s2 = q.s1;
    n.d1 = bus.data;
    n.d2 = q.d1;
    n.st1 = bus_style_straps;
    n.st2 = q.st1;
    // straps are static: taken once the synchroniser has filled
    if (q.boot != hbd_pkg::BOOT_DONE) begin
      n.boot = q.boot + 2'h1;
    end
    if (q.boot == hbd_pkg::BOOT_TAKE) begin
      n.style = q.st2;
    end
    // ----------------------------------------------------------------
    // function decode
    // ----------------------------------------------------------------
    sel = ~q.s2[4] & q.s2[3];
    a0 = q.s2[2];
    rp = q.s2[1];
    wp = q.s2[0];
    if (q.style == hbd_pkg::STRAP_ENA) begin
      rd_now = sel & wp & a0 & rp;
      wr_now = sel & wp & ~rp;
    end else if (q.style == hbd_pkg::STRAP_LDS) begin
      rd_now = sel & ~wp & a0 & rp;
      wr_now = sel & ~wp & ~rp;
    end else begin
      // unknown strap codes fall back to separate strobes
      rd_now = sel & a0 & ~rp & wp;
      wr_now = sel & rp & ~wp;
    end
    n.rd_act = rd_now;
    n.wr_act = wr_now;
    // read: drive the bus for as long as the strobe is seen active
    n.doe = rd_now;
    n.rd_stb = rd_now & ~q.rd_act;
    if (rd_now & ~q.rd_act) begin
      n.dout = rd_value;
    end
    // ----------------------------------------------------------------
    // two-entry write buffer
    // ----------------------------------------------------------------
    pop = q.v[0] & wr_ready;
    if (pop) begin
      n.v = {1'b0, q.v[1]};
      n.w[0] = q.w[1];
    end
    acc = q.pend & ~n.v[1];
    if (acc) begin
      if (!n.v[0]) begin
        n.v[0] = 1'b1;
        n.w[0] = q.pend_w;
      end else begin
        n.v[1] = 1'b1;
        n.w[1] = q.pend_w;
      end
    end
    n.pend = q.pend & ~acc;
    // a new write with the holding slot still stalled is dropped
    if (wr_now & ~q.wr_act) begin
      if (n.pend) begin
        n.ovr = 1'b1;
      end else begin
        n.pend = 1'b1;
        n.pend_w = {a0, q.d2};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign wr_valid = q.v[0];
  assign wr_is_cmd = q.w[0][8];
  assign wr_data = q.w[0][7:0];
  assign rd_strobe = q.rd_stb;
  assign overrun = q.ovr;
  assign bus.dev_dout = q.dout;
  assign bus.dev_doe = q.doe;

endmodule

// ### hbd_host.sv
// hbd_host: host end; turns user requests into parallel bus cycles in
// the selected strobe style. assumes the device end on the same clock.
// assumes style only moves while the sequencer is idle.
`timescale 1ns/1ps
module hbd_host (
  input wire logic clock,
  input wire logic rst_n,
  hbd_bus_if.host bus,
  input wire logic [2:0] style,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_kind,
  input wire logic [7:0] req_data,
  output logic resp_valid,
  output logic [7:0] resp_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // sequencer
    hbd_pkg::hbd_hstate_t st;
    logic [3:0] cnt;
    logic [1:0] kind;
    logic [2:0] style;
    // synchronised data bus
    logic [7:0] d1;
    logic [7:0] d2;
    // pin registers
    logic cs_n;
    logic as;
    logic a0;
    logic rd;
    logic wr;
    logic [7:0] dout;
    logic doe;
    // user side
    logic rdy;
    logic rsp_v;
    logic [7:0] rsp_d;
  } hbd_host_st_t;

  hbd_host_st_t q;
  hbd_host_st_t n;

  localparam hbd_host_st_t HOST_RST = '{
    st: hbd_pkg::HS_IDLE,
    cnt: 4'h0,
    kind: hbd_pkg::KIND_CMD,
    style: hbd_pkg::STRAP_SEP,
    d1: 8'h00,
    d2: 8'h00,
    cs_n: 1'b1,
    as: 1'b0,
    a0: 1'b0,
    rd: 1'b1,
    wr: 1'b1,
    dout: 8'h00,
    doe: 1'b0,
    rdy: 1'b0,
    rsp_v: 1'b0,
    rsp_d: 8'h00
  };

  always_comb begin
    logic is_rd;
    logic strobe_on;
    logic idle_wr;
    is_rd = 1'b0;
    strobe_on = 1'b0;
    idle_wr = 1'b0;
    n = q;
    n.d1 = bus.data;
    n.d2 = q.d1;
    n.rsp_v = 1'b0;
    is_rd = (q.kind == hbd_pkg::KIND_READ);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    case (q.st)
      hbd_pkg::HS_IDLE: begin
        n.rdy = 1'b1;
        // rest levels track the style so, from the first clock after reset, an enable pin never idles high
        n.style = style;
        if (req_valid && q.rdy) begin
          n.rdy = 1'b0;
          // an undefined kind goes out as a data write, never a read
          if (req_kind == hbd_pkg::KIND_READ ||
              req_kind == hbd_pkg::KIND_CMD) begin
            n.kind = req_kind;
          end else begin
            n.kind = hbd_pkg::KIND_DATA;
          end
          n.dout = req_data;
          // style is latched per transfer, never changed mid-cycle
          n.style = style;
          n.cnt = hbd_pkg::SETUP_LAST;
          n.st = hbd_pkg::HS_SETUP;
        end
      end

      hbd_pkg::HS_SETUP: begin
        if (q.cnt == 4'h0) begin
          n.cnt = hbd_pkg::STROBE_LAST;
          n.st = hbd_pkg::HS_STROBE;
        end else begin
          n.cnt = q.cnt - 4'h1;
        end
      end

      hbd_pkg::HS_STROBE: begin
        if (q.cnt == 4'h0) begin
          // sampled last, after the device has had time to drive
          if (is_rd) begin
            n.rsp_v = 1'b1;
            n.rsp_d = q.d2;
          end
          n.cnt = hbd_pkg::HOLD_LAST;
          n.st = hbd_pkg::HS_HOLD;
        end else begin
          n.cnt = q.cnt - 4'h1;
        end
      end

      hbd_pkg::HS_HOLD: begin
        if (q.cnt == 4'h0) begin
          n.st = hbd_pkg::HS_IDLE;
        end else begin
          n.cnt = q.cnt - 4'h1;
        end
      end

      default: begin
        n.st = hbd_pkg::HS_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // pin levels, all from the next state
    // ----------------------------------------------------------------
    strobe_on = (n.st == hbd_pkg::HS_STROBE);
    if (n.st == hbd_pkg::HS_IDLE) begin
      n.cs_n = 1'b1;
      n.as = 1'b0;
      n.doe = 1'b0;
    end else begin
      n.cs_n = 1'b0;
      n.as = 1'b1;
      // select stays put from setup through hold
      n.a0 = (n.kind != hbd_pkg::KIND_DATA);
      // data held from setup through hold of a write
      n.doe = (n.kind != hbd_pkg::KIND_READ);
    end

    // ----------------------------------------------------------------
    // strobe pins per style
    // ----------------------------------------------------------------
    is_rd = (n.kind == hbd_pkg::KIND_READ);
    if (n.st == hbd_pkg::HS_IDLE) begin
      idle_wr = 1'b1;
    end
    if (n.style == hbd_pkg::STRAP_ENA) begin
      // read/write select on rd pin, enable high on wr pin
      n.rd = idle_wr | is_rd;
      n.wr = strobe_on;
    end else if (n.style == hbd_pkg::STRAP_LDS) begin
      // read/write select on rd pin, low data strobe on wr pin
      n.rd = idle_wr | is_rd;
      n.wr = ~strobe_on;
    end else begin
      // only one of the two strobes can ever be low
      n.rd = ~(strobe_on & is_rd);
      n.wr = ~(strobe_on & ~is_rd);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= HOST_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.cs_n = q.cs_n;
  assign bus.address_strobe = q.as;
  assign bus.addr = {hbd_pkg::HOST_BASE_ADDR, q.a0};
  assign bus.rd_pin = q.rd;
  assign bus.wr_pin = q.wr;
  assign bus.host_dout = q.dout;
  assign bus.host_doe = q.doe;
  assign req_ready = q.rdy;
  assign resp_valid = q.rsp_v;
  assign resp_data = q.rsp_d;

endmodule

// ### hbd_pkg.sv
// hbd_pkg: shared constants and types for the host bus function decoder.
// assumes both ends and the interface run on one 125 MHz clock.
package hbd_pkg;

  // ----------------------------------------------------------------
  // bus style strap codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_SEP = 3'h0;
  localparam logic [2:0] STRAP_ENA = 3'h1;
  localparam logic [2:0] STRAP_LDS = 3'h2;

  // ----------------------------------------------------------------
  // request kinds on the host user port
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;

  // ----------------------------------------------------------------
  // bus timing, host side
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_NS = 16;
  localparam int STROBE_NS = 96;
  localparam int HOLD_NS = 32;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // addresses, widths and reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] HOST_BASE_ADDR = 15'h0000;
  localparam logic [7:0] BUS_FLOAT = 8'hFF;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WORD_W = 9;
  localparam logic [1:0] BOOT_DONE = 2'h3;
  localparam logic [1:0] BOOT_TAKE = 2'h2;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SETUP = 4'h2,
    HS_STROBE = 4'h4,
    HS_HOLD = 4'h8
  } hbd_hstate_t;

endpackage

// ### tb.sv
// tb: joins host and device ends, runs each bus style and a stall.
// assumes the package and interface are compiled first.
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] style = 3'h0;
  logic req_valid = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [7:0] req_data = 8'h00;
  logic wr_ready = 1'b0;
  logic [7:0] rd_value = 8'h00;
  logic req_ready, resp_valid, wr_valid, wr_is_cmd, rd_strobe, overrun;
  logic [7:0] resp_data, wr_data;
  logic [8:0] got[$];
  int n_rd;
  logic wv_seen = 1'b0;
  logic [8:0] ww_seen = 9'h000;
  int bad_count = 0;
  int samples_checked = 0;

  hbd_bus_if bus();
  always #4 clock = ~clock;
  hbd_host u_hbd_host(.clock(clock), .rst_n(rst_n), .bus(bus),
    .style(style), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_data(req_data), .resp_valid(resp_valid),
    .resp_data(resp_data));
  hbd_dev u_hbd_dev(.clock(clock), .rst_n(rst_n), .bus(bus),
    .bus_style_straps(style), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_is_cmd(wr_is_cmd), .wr_data(wr_data), .rd_value(rd_value),
    .rd_strobe(rd_strobe), .overrun(overrun));
  hbd_assertions u_hbd_assertions(.clock(clock), .rst_n(rst_n),
    .cs_n(bus.cs_n), .address_strobe(bus.address_strobe),
    .addr(bus.addr), .rd_pin(bus.rd_pin), .wr_pin(bus.wr_pin),
    .host_dout(bus.host_dout), .host_doe(bus.host_doe),
    .dev_doe(bus.dev_doe), .bus_style_straps(style));

  // ----------------------------------------------------------------
  // collectors and helpers
  // ----------------------------------------------------------------
  // outputs copied at the falling edge, where they are settled; the
  // rising edge then sees the word the buffer hands over there
  always @(negedge clock) begin
    wv_seen = wr_valid;
    ww_seen = {wr_is_cmd, wr_data};
    if (rd_strobe === 1'b1) begin
      n_rd++;
    end
  end

  always @(posedge clock) begin
    if (wv_seen === 1'b1 && wr_ready === 1'b1) begin
      got.push_back(ww_seen);
    end
  end

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e);
      bad_count++;
    end
  endtask

  // straps change only while reset is held
  task automatic do_reset(input logic [2:0] s);
    rst_n = 1'b0;
    style = s;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
  endtask

  task automatic req(input logic [1:0] k, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    chk({8'h00, req_ready}, 9'h001);
    req_valid = 1'b1;
    req_kind = k;
    req_data = d;
    @(negedge clock);
    req_valid = 1'b0;
  endtask

  task automatic wait_resp(input logic [7:0] e);
    int n;
    n = 0;
    while (resp_valid !== 1'b1 && n < 30) begin
      @(negedge clock);
      n++;
    end
    chk({resp_valid, resp_data}, {1'b1, e});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_styles();
    logic [2:0] codes[4];
    logic [7:0] v;
    // an unassigned strap code must behave as separate strobes
    codes = '{hbd_pkg::STRAP_SEP, hbd_pkg::STRAP_ENA, hbd_pkg::STRAP_LDS,
              3'h7};
    for (int s = 0; s < 4; s++) begin
      do_reset(codes[s]);
      wr_ready = 1'b1;
      got.delete();
      n_rd = 0;
      v = 8'hC3 ^ 8'(s);
      rd_value = v;
      req(hbd_pkg::KIND_CMD, 8'hA5);
      req(hbd_pkg::KIND_DATA, v);
      req(hbd_pkg::KIND_READ, 8'h00);
      wait_resp(v);
      chk(9'(got.size()), 9'h002);
      chk(got[0], {1'b1, 8'hA5});
      chk(got[1], {1'b0, v});
      chk(9'(n_rd), 9'h001);
      chk({8'h00, overrun}, 9'h000);
    end
  endtask

  // receiver stalls: two buffered, one pending, fourth dropped
  task automatic t_stall();
    do_reset(hbd_pkg::STRAP_SEP);
    wr_ready = 1'b0;
    got.delete();
    for (int i = 1; i < 5; i++) begin
      req(hbd_pkg::KIND_DATA, 8'(8'h11 * i));
    end
    repeat (25) @(negedge clock);
    chk({8'h00, overrun}, 9'h001);
    chk({8'h00, wr_valid}, 9'h001);
    wr_ready = 1'b1;
    repeat (16) @(negedge clock);
    chk(9'(got.size()), 9'h003);
    for (int i = 0; i < 3; i++) begin
      chk(got[i], {1'b0, 8'(8'h11 * (i + 1))});
    end
    chk({8'h00, wr_valid}, 9'h000);
  endtask

  task automatic summarize();
    $display("checks=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    t_styles();
    t_stall();
    summarize();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
